// ===== src/sac_top.sv
// Purpose: Serial control port of a two-channel log attenuator
// Assumes: i_sclk is the link clock; i_load is high outside frames
// Notes: Shift logic on i_sclk, decode and settings on i_mclk
`timescale 1ns/100ps
module sac_top #(
    parameter int CH_COUNT = sac_pkg::NUM_CH
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_sclk,
    input wire logic i_sdata,
    input wire logic i_load,
    output logic o_sdout,
    output sac_pkg::sac_setting_t o_ch1,
    output sac_pkg::sac_setting_t o_ch2,
    output logic o_update
);
    logic [15:0] shift_r;
    logic [15:0] hold_r;
    logic load_m1_r;
    logic load_s_r;
    logic load_d_r;
    logic [15:0] hold_m1_r;
    logic [15:0] hold_s_r;
    sac_pkg::sac_frame_t frame;
    sac_pkg::sac_setting_t set_nxt;

    // Decode an attenuation code into a tap setting
    function automatic sac_pkg::sac_setting_t decode(input logic [7:0] code);
        sac_pkg::sac_setting_t s;
        s.mute = (code >= sac_pkg::MUTE_FIRST);
        s.coarse = (code > sac_pkg::FINE_LAST) && !s.mute;
        s.tap = s.mute ? sac_pkg::TAP_MUTE_RST : code[6:0];
        return s;
    endfunction

    // Link-side shift register, frozen while latch is high
    always_ff @(posedge i_sclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            shift_r <= sac_pkg::FRAME_RST;
        end else if (!i_load) begin
            shift_r <= {shift_r[14:0], i_sdata};
        end
    end

    // Serial out shows bit the next shift will displace, on falling clock
    always_ff @(negedge i_sclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sdout <= 1'b0;
        end else begin
            o_sdout <= shift_r[15];
        end
    end

    // Hold frame stable in link domain once latch is high
    always_ff @(posedge i_sclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hold_r <= sac_pkg::FRAME_RST;
        end else if (!i_load) begin
            hold_r <= {shift_r[14:0], i_sdata};
        end
    end

    // Synchronise latch line into system clock
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            load_m1_r <= 1'b1;
            load_s_r <= 1'b1;
            load_d_r <= 1'b1;
        end else begin
            load_m1_r <= i_load;
            load_s_r <= load_m1_r;
            load_d_r <= load_s_r;
        end
    end

    // Frame words are static while latch high; two stages settle them
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hold_m1_r <= sac_pkg::FRAME_RST;
            hold_s_r <= sac_pkg::FRAME_RST;
        end else begin
            hold_m1_r <= hold_r;
            hold_s_r <= hold_m1_r;
        end
    end

    // Frame fields and decoded setting
    always_comb begin
        frame = hold_s_r;
        set_nxt = decode(frame.atten);
    end

    // Apply on latch rise to the addressed channel only
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_ch1 <= '{mute: 1'b1, coarse: 1'b0, tap: sac_pkg::TAP_MUTE_RST};
            o_ch2 <= '{mute: 1'b1, coarse: 1'b0, tap: sac_pkg::TAP_MUTE_RST};
            o_update <= 1'b0;
        end else begin
            o_update <= 1'b0;
            if (load_s_r && !load_d_r) begin
                if (frame.chan == sac_pkg::CH1_SEL) begin
                    o_ch1 <= set_nxt;
                    o_update <= 1'b1;
                end else if (frame.chan == sac_pkg::CH2_SEL && CH_COUNT > 1) begin
                    o_ch2 <= set_nxt;
                    o_update <= 1'b1;
                end
            end
        end
    end
endmodule

// ===== src/sac_pkg.sv
// Purpose: Shared constants and types for the serial attenuator control block
// Assumes: 16-bit frames, channel byte first, MSB first
// Notes: Attenuation held per channel as 7-bit tap plus mute and coarse flags
package sac_pkg;
    localparam int FRAME_BITS = 16;
    localparam int BYTE_BITS = 8;
    localparam int NUM_CH = 2;
    localparam logic [7:0] CH1_SEL = 8'h00;
    localparam logic [7:0] CH2_SEL = 8'h01;
    localparam logic [7:0] FINE_LAST = 8'h5F;
    localparam logic [7:0] COARSE_LAST = 8'h7E;
    localparam logic [7:0] MUTE_FIRST = 8'h7F;
    localparam logic [15:0] FRAME_RST = 16'h0000;
    localparam logic [6:0] TAP_MUTE_RST = 7'h7F;
    // Setup of latch line before first clock, in ns
    localparam int SETUP_NS = 150;

    typedef struct packed {
        logic [7:0] chan;
        logic [7:0] atten;
    } sac_frame_t;

    typedef struct packed {
        logic mute;
        logic coarse;
        logic [6:0] tap;
    } sac_setting_t;
endpackage

// ===== dv/sac_top_sva.sv
// Purpose: sac_top output checks. Assumes: {mute,coarse,tap}. Notes: bound below.
`timescale 1ns/100ps
module sac_top_sva (
    input logic i_mclk,
    input logic i_rst_n,
    input logic i_load,
    input sac_pkg::sac_setting_t o_ch1,
    input sac_pkg::sac_setting_t o_ch2,
    input logic o_update
);
    // System clock checks
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    AST_M1: assert property (o_ch1.mute |-> o_ch1.tap == 7'h7F) else $error("m1");
    AST_M2: assert property (o_ch2.mute |-> !o_ch2.coarse) else $error("m2");
    AST_CO: assert property (o_ch1.coarse |-> o_ch1.tap > 7'h5F) else $error("co");
    AST_FI: assert property (!o_ch2[8:7] |-> o_ch2.tap < 7'h60) else $error("fi");
    AST_PU: assert property (o_update |=> !o_update) else $error("pu");
    AST_CH: assert property ($changed(o_ch1) || $changed(o_ch2) |-> o_update) else $error("ch");
    AST_ON: assert property (o_update |-> !($changed(o_ch1) && $changed(o_ch2))) else $error("on");
    AST_LD: assert property (o_update |-> $past(i_load, 3) && !$past(i_load, 6)) else $error("ld");
endmodule
bind sac_top sac_top_sva sac_top_sva_i (.*);

// ===== dv/sac_mcu.sv
// Purpose: serial controller model. Assumes: link clock only in frames. Notes: checks o_sdout.
`timescale 1ns/100ps
module sac_mcu (
    input logic i_sdout,
    output logic o_sclk = 1'b0,
    output logic o_sdata = 1'b0,
    output logic o_load = 1'b1
);
    logic [16:0] hist = '0;
    int errs = 0;
    // Load low early, MSB first, 15 ns link clock
    task send(input logic [31:0] f, input int n);
        o_load <= 1'b0;
        #150;
        for (int k = n - 1; k >= 0; k--) begin
            o_sdata <= f[k];
            // Bit about to be displaced was sent sixteen rises ago
            #7.5 errs += int'(i_sdout !== hist[15]);
            hist = {hist[15:0], f[k]};
            o_sclk <= 1'b1;
            #7.5 o_sclk <= 1'b0;
        end
        #7.5 o_load <= 1'b1;
        o_sdata <= ~o_sdata;
    endtask
endmodule

// ===== dv/serial_attenuator_control_test.sv
// Purpose: sac_top bench. Assumes: model drives link. Notes: settings model per channel.
`timescale 1ns/100ps
module serial_attenuator_control_test;
    logic i_mclk = 1'b0, i_rst_n = 1'b0, i_sclk, i_sdata, i_load, o_sdout, o_update;
    sac_pkg::sac_setting_t o_ch1, o_ch2;
    logic [8:0] ex[2] = '{9'h17F, 9'h17F};
    logic [7:0] cd[4] = '{8'h5F, 8'h60, 8'h7E, 8'h7F};
    int n_errors = 0, checks = 0, seed = 70869;
    int n_upd = 0, x_upd = 0;
    // Count update pulses seen from the design
    always @(posedge i_mclk) if (o_update === 1'b1) n_upd++;
    // Clock and watchdog
    initial forever #5 i_mclk = ~i_mclk;
    initial #99000 complete_run(1);
    sac_mcu sac_mcu_i (.i_sdout(o_sdout), .o_sclk(i_sclk), .o_sdata(i_sdata), .o_load(i_load));
    sac_top sac_top_i (.*);
    task check(input logic [8:0] s, input logic [8:0] w);
        checks++;
        if (s !== w) n_errors++;
        if (s !== w) $display("CHECK FAILED %0t got %h exp %h", $time, s, w);
    endtask
    task complete_run(input int e);
        n_errors += e;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // One frame, then both channels against the model
    task frame(input logic [7:0] c, input logic [7:0] a, input int n);
        @(posedge i_mclk);
        sac_mcu_i.send({16'($random(seed)), c, a}, n);
        if (c < 8'h02) ex[c[0]] = {a > 8'h7E, a > 8'h5F && a < 8'h7F, a > 8'h7E ? 7'h7F : a[6:0]};
        if (c < 8'h02) x_upd++;
        repeat (8) @(negedge i_mclk);
        check(o_ch1, ex[0]);
        check(o_ch2, ex[1]);
        check(9'(n_upd), 9'(x_upd));
    endtask
    initial begin
        repeat (10) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        repeat (4) @(negedge i_mclk) begin
            check(o_ch1, 9'h17F);
            check(o_ch2, 9'h17F);
        end
        for (int j = 0; j < 8; j++) frame(8'(j % 2), cd[j / 2], 16);
        $display("codes done");
        repeat (30) frame(8'($random(seed) & 3), 8'($random(seed)), 32);
        check(9'(sac_mcu_i.errs != 0), 9'h000);
        $display("chain done");
        complete_run(0);
    end
endmodule
